// *** ses_map.svh ***
// status event summary: bit positions, valid masks and reset values
// assumes: included by bare name from every design file that needs it
`ifndef SES_MAP_SVH
`define SES_MAP_SVH

// questionable group condition positions
`define SES_Q_OVR_BIT 0
`define SES_Q_RATE_BIT 2
`define SES_Q_CALERR_BIT 8

// operation group condition positions
`define SES_O_CAL_BIT 0
`define SES_O_ARM_BIT 6
`define SES_O_BUSY_BIT 8
`define SES_O_READY_BIT 9

// positions that carry a condition at all
`define SES_Q_VALID 16'h0105
`define SES_O_VALID 16'h0341

// reset values
`define SES_RISE_RST 16'hFFFF
`define SES_FALL_RST 16'h0000
`define SES_ENABLE_RST 16'h0000
`define SES_EVENT_RST 16'h0000
`define SES_COND_RST 16'h0000
`define SES_RSP_RST 16'h0000

`endif

// *** ses_pkg.sv ***
// status event summary: command and group types, shared edge function
// assumes: nothing beyond the map header for numeric constants
package ses_pkg;

  typedef logic [15:0] ses_word_t;

  typedef enum logic [3:0] {
    SES_CMD_NOP,
    SES_CMD_RD_COND,
    SES_CMD_RD_EVENT,
    SES_CMD_RD_ENABLE,
    SES_CMD_WR_ENABLE,
    SES_CMD_RD_RISE,
    SES_CMD_WR_RISE,
    SES_CMD_RD_FALL,
    SES_CMD_WR_FALL,
    SES_CMD_PRESET,
    SES_CMD_CLEAR_STATUS
  } ses_cmd_t;

  typedef enum logic {
    SES_GRP_QUES,
    SES_GRP_OPER
  } ses_grp_t;

  // bits that changed in the direction the filter lets through
  function automatic ses_word_t ses_edges(input ses_word_t prev, input ses_word_t cur,
                                          input ses_word_t mask, input logic rising);
    if (rising) begin
      ses_edges = ~prev & cur & mask;
    end else begin
      ses_edges = prev & ~cur & mask;
    end
  endfunction

endpackage

// *** ses_group.sv ***
// status event summary: one status group (filters, event latch, enable, summary)
// assumes: condition word and strobes come from logic on core_clk_i
`timescale 1ns/100ps
`include "ses_map.svh"
module ses_group import ses_pkg::*; #(
  parameter ses_word_t VALID_MASK = `SES_Q_VALID
) (
  // clock, reset, enable
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  // condition and command strobes
  input wire ses_word_t cond_i,
  input wire logic wr_rise_i,
  input wire logic wr_fall_i,
  input wire logic wr_enable_i,
  input wire ses_word_t wr_data_i,
  input wire logic rd_event_i,
  input wire logic clear_status_i,
  input wire logic preset_i,
  // register contents and summary
  output ses_word_t rise_o,
  output ses_word_t fall_o,
  output ses_word_t enable_o,
  output ses_word_t event_o,
  output logic summary_o
);

  ses_word_t prev_ff;
  ses_word_t rise_ff;
  ses_word_t fall_ff;
  ses_word_t enable_ff;
  ses_word_t event_ff;
  ses_word_t rise_edges;
  ses_word_t fall_edges;
  ses_word_t nxt_event;

  // -----------------------------------------------------------------
  // transition filters
  // -----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      prev_ff <= `SES_COND_RST;
    end else if (ce_i) begin
      prev_ff <= cond_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      rise_ff <= `SES_RISE_RST;
      fall_ff <= `SES_FALL_RST;
    end else if (ce_i) begin
      if (wr_rise_i) begin
        rise_ff <= wr_data_i;
      end
      if (wr_fall_i) begin
        fall_ff <= wr_data_i;
      end
    end
  end

  assign rise_edges = ses_edges(prev_ff, cond_i, rise_ff & VALID_MASK, 1'b1);
  assign fall_edges = ses_edges(prev_ff, cond_i, fall_ff & VALID_MASK, 1'b0);

  // -----------------------------------------------------------------
  // event latch and enable mask
  // -----------------------------------------------------------------
  // a new edge in the clearing cycle survives the clear
  always_comb begin
    nxt_event = (rd_event_i || clear_status_i) ? `SES_EVENT_RST : event_ff;
    nxt_event = nxt_event | rise_edges | fall_edges;
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      event_ff <= `SES_EVENT_RST;
    end else if (ce_i) begin
      event_ff <= nxt_event;
    end
  end

  // preset outranks a write in the same cycle
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      enable_ff <= `SES_ENABLE_RST;
    end else if (ce_i) begin
      if (preset_i) begin
        enable_ff <= `SES_ENABLE_RST;
      end else if (wr_enable_i) begin
        enable_ff <= wr_data_i;
      end
    end
  end

  assign summary_o = |(event_ff & enable_ff);
  assign rise_o = rise_ff;
  assign fall_o = fall_ff;
  assign enable_o = enable_ff;
  assign event_o = event_ff;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  a_rise_latches: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (ce_i && rise_edges != 16'h0000) |=> ((event_ff & $past(rise_edges)) == $past(rise_edges)))
    else $error("rising edge not latched");
  a_fall_latches: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (ce_i && fall_edges != 16'h0000) |=> ((event_ff & $past(fall_edges)) == $past(fall_edges)))
    else $error("falling edge not latched");
  a_event_sticky: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (!rd_event_i && !clear_status_i) |=> ((event_ff & $past(event_ff)) == $past(event_ff)))
    else $error("event bit dropped without clear");
  a_read_clears: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (ce_i && rd_event_i && rise_edges == 16'h0000 && fall_edges == 16'h0000) |=> event_ff == 16'h0000)
    else $error("event read did not clear");
  a_unused_quiet: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (event_ff & ~VALID_MASK) == 16'h0000)
    else $error("event on unused position");
  a_preset_mask: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (ce_i && preset_i) |=> (enable_ff == 16'h0000 && !summary_o))
    else $error("preset left enable set");
  a_summary_or: assert property (@(posedge core_clk_i) disable iff (srst_i)
    $rose(summary_o) |-> ($past(nxt_event) & enable_ff) != 16'h0000)
    else $error("summary without enabled event");

endmodule

// *** ses_status_top.sv ***
// status event summary: questionable and operation status groups
// assumes: monitor levels are asynchronous; sequencer strobes and
// commands come from logic on core_clk_i
`timescale 1ns/100ps
`include "ses_map.svh"
module ses_status_top import ses_pkg::*; (
  // clock, reset, enable
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  // asynchronous monitor levels
  input wire logic ovr_single_i,
  input wire logic ovr_diff_i,
  input wire logic rate_err_i,
  input wire logic cal_store_err_i,
  // measurement sequencer, same clock
  input wire logic meas_active_i,
  input wire logic cal_in_progress_i,
  input wire logic wait_arm_enter_i,
  input wire logic start_arm_i,
  input wire logic abort_i,
  input wire logic init_imm_i,
  input wire logic meas_idle_i,
  input wire logic seg_ready_i,
  input wire logic seg_partition_i,
  input wire logic inst_rst_i,
  // status commands
  input wire logic cmd_valid_i,
  input wire ses_cmd_t cmd_op_i,
  input wire ses_grp_t cmd_grp_i,
  input wire ses_word_t cmd_data_i,
  // answers and summaries
  output logic rsp_valid_o,
  output ses_word_t rsp_data_o,
  output logic ques_summary_o,
  output logic oper_summary_o,
  output logic service_req_o
);

  // a command aimed at one group with one opcode
  function automatic logic cmd_hit(input logic valid, input ses_cmd_t op, input ses_grp_t grp,
                                   input ses_cmd_t want_op, input ses_grp_t want_grp);
    cmd_hit = valid && (op == want_op) && (grp == want_grp);
  endfunction

  // -----------------------------------------------------------------
  // monitor synchronisers
  // -----------------------------------------------------------------
  logic [3:0] mon_meta_ff;
  logic [3:0] mon_sync_ff;

  // first stage feeds only the second stage
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      mon_meta_ff <= 4'h0;
      mon_sync_ff <= 4'h0;
    end else if (ce_i) begin
      mon_meta_ff <= {cal_store_err_i, rate_err_i, ovr_diff_i, ovr_single_i};
      mon_sync_ff <= mon_meta_ff;
    end
  end

  // -----------------------------------------------------------------
  // questionable condition
  // -----------------------------------------------------------------
  logic input_overrange_flag_ff;
  logic rate_err_ff;
  ses_word_t ques_cond;

  // overrange only counts inside a measurement sequence
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      input_overrange_flag_ff <= 1'b0;
    end else if (ce_i) begin
      if (inst_rst_i) begin
        input_overrange_flag_ff <= 1'b0;
      end else begin
        input_overrange_flag_ff <= (mon_sync_ff[0] | mon_sync_ff[1]) & meas_active_i;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      rate_err_ff <= 1'b0;
    end else if (ce_i) begin
      rate_err_ff <= mon_sync_ff[2] & ~inst_rst_i;
    end
  end

  // storage error is a live level, so an instrument reset cannot hide it
  always_comb begin
    ques_cond = `SES_COND_RST;
    ques_cond[`SES_Q_OVR_BIT] = input_overrange_flag_ff;
    ques_cond[`SES_Q_RATE_BIT] = rate_err_ff;
    ques_cond[`SES_Q_CALERR_BIT] = mon_sync_ff[3];
  end

  // -----------------------------------------------------------------
  // operation condition
  // -----------------------------------------------------------------
  logic cal_in_progress_flag_ff;
  logic arm_wait_ff;
  logic busy_ff;
  logic ready_ff;
  ses_word_t oper_cond;

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      cal_in_progress_flag_ff <= 1'b0;
    end else if (ce_i) begin
      cal_in_progress_flag_ff <= cal_in_progress_i & ~inst_rst_i;
    end
  end

  // arm arriving with the entry strobe means no wait at all
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      arm_wait_ff <= 1'b0;
    end else if (ce_i) begin
      if (inst_rst_i || start_arm_i || abort_i) begin
        arm_wait_ff <= 1'b0;
      end else if (wait_arm_enter_i) begin
        arm_wait_ff <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      busy_ff <= 1'b0;
    end else if (ce_i) begin
      if (inst_rst_i) begin
        busy_ff <= 1'b0;
      end else if (init_imm_i) begin
        busy_ff <= 1'b1;
      end else if (meas_idle_i || abort_i) begin
        busy_ff <= 1'b0;
      end
    end
  end

  // partitioning wins, since the segment is not usable then
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      ready_ff <= 1'b0;
    end else if (ce_i) begin
      if (inst_rst_i || seg_partition_i) begin
        ready_ff <= 1'b0;
      end else begin
        ready_ff <= seg_ready_i;
      end
    end
  end

  always_comb begin
    oper_cond = `SES_COND_RST;
    oper_cond[`SES_O_CAL_BIT] = cal_in_progress_flag_ff;
    oper_cond[`SES_O_ARM_BIT] = arm_wait_ff;
    oper_cond[`SES_O_BUSY_BIT] = busy_ff;
    oper_cond[`SES_O_READY_BIT] = ready_ff;
  end

  // -----------------------------------------------------------------
  // status groups
  // -----------------------------------------------------------------
  logic clear_status;
  logic preset;
  ses_word_t q_rise, q_fall, q_enable, q_event;
  ses_word_t o_rise, o_fall, o_enable, o_event;

  assign clear_status = cmd_valid_i && (cmd_op_i == SES_CMD_CLEAR_STATUS);
  assign preset = cmd_valid_i && (cmd_op_i == SES_CMD_PRESET);

  ses_group #(.VALID_MASK(`SES_Q_VALID)) u_ques (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .ce_i(ce_i),
    .cond_i(ques_cond),
    .wr_rise_i(cmd_hit(cmd_valid_i, cmd_op_i, cmd_grp_i, SES_CMD_WR_RISE, SES_GRP_QUES)),
    .wr_fall_i(cmd_hit(cmd_valid_i, cmd_op_i, cmd_grp_i, SES_CMD_WR_FALL, SES_GRP_QUES)),
    .wr_enable_i(cmd_hit(cmd_valid_i, cmd_op_i, cmd_grp_i, SES_CMD_WR_ENABLE, SES_GRP_QUES)),
    .wr_data_i(cmd_data_i),
    .rd_event_i(cmd_hit(cmd_valid_i, cmd_op_i, cmd_grp_i, SES_CMD_RD_EVENT, SES_GRP_QUES)),
    .clear_status_i(clear_status),
    .preset_i(preset),
    .rise_o(q_rise),
    .fall_o(q_fall),
    .enable_o(q_enable),
    .event_o(q_event),
    .summary_o(ques_summary_o)
  );

  // same machinery for the operation group
  ses_group #(.VALID_MASK(`SES_O_VALID)) u_oper (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .ce_i(ce_i),
    .cond_i(oper_cond),
    .wr_rise_i(cmd_hit(cmd_valid_i, cmd_op_i, cmd_grp_i, SES_CMD_WR_RISE, SES_GRP_OPER)),
    .wr_fall_i(cmd_hit(cmd_valid_i, cmd_op_i, cmd_grp_i, SES_CMD_WR_FALL, SES_GRP_OPER)),
    .wr_enable_i(cmd_hit(cmd_valid_i, cmd_op_i, cmd_grp_i, SES_CMD_WR_ENABLE, SES_GRP_OPER)),
    .wr_data_i(cmd_data_i),
    .rd_event_i(cmd_hit(cmd_valid_i, cmd_op_i, cmd_grp_i, SES_CMD_RD_EVENT, SES_GRP_OPER)),
    .clear_status_i(clear_status),
    .preset_i(preset),
    .rise_o(o_rise),
    .fall_o(o_fall),
    .enable_o(o_enable),
    .event_o(o_event),
    .summary_o(oper_summary_o)
  );

  assign service_req_o = ques_summary_o | oper_summary_o;

  // -----------------------------------------------------------------
  // command answers
  // -----------------------------------------------------------------
  logic rsp_valid_ff;
  ses_word_t rsp_data_ff;
  logic nxt_rsp_valid;
  ses_word_t nxt_rsp_data;
  logic is_oper;

  assign is_oper = (cmd_grp_i == SES_GRP_OPER);

  // event read returns the value before its clear takes hold;
  // an idle opcode must not refresh the held answer
  always_comb begin
    nxt_rsp_valid = cmd_valid_i;
    nxt_rsp_data = rsp_data_ff;
    case (cmd_valid_i ? cmd_op_i : SES_CMD_NOP)
      SES_CMD_RD_COND: nxt_rsp_data = is_oper ? oper_cond : ques_cond;
      SES_CMD_RD_EVENT: nxt_rsp_data = is_oper ? o_event : q_event;
      SES_CMD_RD_ENABLE: nxt_rsp_data = is_oper ? o_enable : q_enable;
      SES_CMD_RD_RISE: nxt_rsp_data = is_oper ? o_rise : q_rise;
      SES_CMD_RD_FALL: nxt_rsp_data = is_oper ? o_fall : q_fall;
      default: nxt_rsp_valid = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      rsp_valid_ff <= 1'b0;
      rsp_data_ff <= `SES_RSP_RST;
    end else if (ce_i) begin
      rsp_valid_ff <= nxt_rsp_valid;
      rsp_data_ff <= nxt_rsp_data;
    end
  end

  assign rsp_valid_o = rsp_valid_ff;
  assign rsp_data_o = rsp_data_ff;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  a_ovr_follows: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (ce_i && !inst_rst_i && meas_active_i && mon_sync_ff[0]) |=> ques_cond[`SES_Q_OVR_BIT])
    else $error("overrange not reported");
  a_ovr_idle_low: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (ce_i && !meas_active_i) |=> !ques_cond[`SES_Q_OVR_BIT])
    else $error("overrange outside measurement");
  a_rate_follows: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (ce_i && !inst_rst_i) |=> (ques_cond[`SES_Q_RATE_BIT] == $past(mon_sync_ff[2])))
    else $error("rate flag mismatch");
  a_calerr_live: assert property (@(posedge core_clk_i) disable iff (srst_i)
    ques_cond[`SES_Q_CALERR_BIT] == mon_sync_ff[3])
    else $error("storage error flag mismatch");
  a_calerr_survives: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (ce_i && inst_rst_i && mon_sync_ff[3]) ##1 (mon_sync_ff[3]) |-> ques_cond[`SES_Q_CALERR_BIT])
    else $error("storage error lost at reset");
  a_reset_clears: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (ce_i && inst_rst_i) |=> (oper_cond == 16'h0000 && !ques_cond[`SES_Q_OVR_BIT]))
    else $error("instrument reset left conditions");
  a_unused_cond: assert property (@(posedge core_clk_i) disable iff (srst_i)
    ((ques_cond & ~`SES_Q_VALID) == 16'h0000) && ((oper_cond & ~`SES_O_VALID) == 16'h0000))
    else $error("condition on unused position");
  a_cond_read: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (ce_i && cmd_valid_i && cmd_op_i == SES_CMD_RD_COND && cmd_grp_i == SES_GRP_OPER)
      |=> (rsp_valid_o && rsp_data_o == $past(oper_cond)))
    else $error("condition read wrong");
  a_cal_bit: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (ce_i && !inst_rst_i) |=> (oper_cond[`SES_O_CAL_BIT] == $past(cal_in_progress_i)))
    else $error("calibration bit mismatch");
  a_arm_bit: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (ce_i && wait_arm_enter_i && !start_arm_i && !abort_i && !inst_rst_i)
      ##1 (ce_i && !start_arm_i && !abort_i && !inst_rst_i) |=> oper_cond[`SES_O_ARM_BIT])
    else $error("arm wait bit not held");
  a_busy_bit: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (ce_i && init_imm_i && !inst_rst_i) |=> oper_cond[`SES_O_BUSY_BIT])
    else $error("busy bit not set");
  a_ready_bit: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (ce_i && seg_partition_i) |=> !oper_cond[`SES_O_READY_BIT])
    else $error("ready during partitioning");
  a_event_read: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (ce_i && cmd_valid_i && cmd_op_i == SES_CMD_RD_EVENT && cmd_grp_i == SES_GRP_QUES)
      |=> (rsp_valid_o && rsp_data_o == $past(q_event)))
    else $error("event read answer wrong");

endmodule

// *** ses_status_top_tb_top.sv ***
// status event summary testbench: directed and random command traffic against an integer model
// assumes: ses_pkg and ses_status_top compiled first; bench drives every input at the falling edge
`timescale 1ns/100ps
module ses_status_top_tb_top import ses_pkg::*;;
  // ----------------------------------------------------------------
  // stimulus and design
  // ----------------------------------------------------------------
  logic core_clk_i = 1'h0;
  logic srst_i = 1'h1;
  logic ce_i = 1'h1;
  // levels: ovr single, ovr diff, rate, cal store, meas, cal, seg ready, partition
  logic [7:0] lvl = 8'h00;
  // pulses: arm enter, start arm, abort, initiate, idle, instrument reset
  logic [5:0] pls = 6'h00;
  logic cmd_valid_i = 1'h0;
  ses_cmd_t cmd_op_i = SES_CMD_NOP;
  ses_grp_t cmd_grp_i = SES_GRP_QUES;
  ses_word_t cmd_data_i = 16'h0000;
  logic rsp_valid_o, ques_summary_o, oper_summary_o, service_req_o;
  ses_word_t rsp_data_o, rd_data;
  logic rv;
  int mismatches = 0, check_count = 0, cycles = 0, seed = 74, r;
  int rise_m[2], fall_m[2], en_m[2], ev_m[2], cond_m[2];
  int arm_m = 0, busy_m = 0;

  always #2.5 core_clk_i = ~core_clk_i;

  ses_status_top dut (.core_clk_i(core_clk_i), .srst_i(srst_i), .ce_i(ce_i),
    .ovr_single_i(lvl[0]), .ovr_diff_i(lvl[1]), .rate_err_i(lvl[2]), .cal_store_err_i(lvl[3]),
    .meas_active_i(lvl[4]), .cal_in_progress_i(lvl[5]), .wait_arm_enter_i(pls[0]),
    .start_arm_i(pls[1]), .abort_i(pls[2]), .init_imm_i(pls[3]), .meas_idle_i(pls[4]),
    .seg_ready_i(lvl[6]), .seg_partition_i(lvl[7]), .inst_rst_i(pls[5]),
    .cmd_valid_i(cmd_valid_i), .cmd_op_i(cmd_op_i), .cmd_grp_i(cmd_grp_i), .cmd_data_i(cmd_data_i),
    .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o), .ques_summary_o(ques_summary_o),
    .oper_summary_o(oper_summary_o), .service_req_o(service_req_o));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic end_sim();
    if (mismatches == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // hang guard: the whole run needs about 1800 cycles
  always @(posedge core_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      mismatches++;
      end_sim();
    end
  end

  task automatic chk(input string n, input int exp, input ses_word_t got);
    check_count++;
    if (got !== ses_word_t'(exp)) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", n, ses_word_t'(exp), got);
    end
  endtask

  // one-cycle command; answer captured at the falling edge after the taking edge
  task automatic cmd(input ses_cmd_t op, input int g, input int d);
    cmd_valid_i = 1'h1;
    cmd_op_i = op;
    cmd_grp_i = ses_grp_t'(g);
    cmd_data_i = ses_word_t'(d);
    @(negedge core_clk_i);
    cmd_valid_i = 1'h0;
    rv = rsp_valid_o;
    rd_data = rsp_data_o;
    @(negedge core_clk_i);
  endtask

  task automatic rd(input ses_cmd_t op, input int g, input int exp, input string n);
    cmd(op, g, 0);
    chk({n, " answer"}, 1, {15'h0000, rv});
    chk(n, exp, rd_data);
  endtask

  task automatic sums();
    chk("ques summary", (ev_m[0] & en_m[0]) != 0, {15'h0000, ques_summary_o});
    chk("oper summary", (ev_m[1] & en_m[1]) != 0, {15'h0000, oper_summary_o});
    chk("service request", ((ev_m[0] & en_m[0]) | (ev_m[1] & en_m[1])) != 0, {15'h0000, service_req_o});
  endtask

  // model step: latch the edges the filters pass between two condition words
  task automatic mdl(input int n0, input int n1);
    int n[2];
    n[0] = n0;
    n[1] = n1;
    for (int g = 0; g < 2; g++) begin
      ev_m[g] |= (~cond_m[g] & n[g] & rise_m[g]) | (cond_m[g] & ~n[g] & fall_m[g]);
      cond_m[g] = n[g];
    end
  endtask

  // instrument reset drops all flags but the storage error; level-following ones for one cycle, so both edges count
  task automatic pulse(input int k);
    pls = 6'h01 << k;
    @(negedge core_clk_i);
    pls = 6'h00;
    case (k)
      0: arm_m = 1;
      1: arm_m = 0;
      2: begin arm_m = 0; busy_m = 0; end
      3: busy_m = 1;
      4: busy_m = 0;
      5: begin arm_m = 0; busy_m = 0; mdl({lvl[3], 8'h00}, 0); end
      default: ;
    endcase
  endtask

  // wait out the synchronisers, then latch the edges the filters pass
  task automatic settle();
    int n[2];
    repeat (6) @(negedge core_clk_i);
    n[0] = ((lvl[0] | lvl[1]) & lvl[4]) | (lvl[2] << 2) | (lvl[3] << 8);
    n[1] = lvl[5] | (arm_m << 6) | (busy_m << 8) | ((lvl[6] & ~lvl[7]) << 9);
    mdl(n[0], n[1]);
    sums();
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(negedge core_clk_i);
    srst_i = 1'h0;
    @(negedge core_clk_i);
    for (int g = 0; g < 2; g++) begin
      rise_m[g] = 16'hFFFF;
      fall_m[g] = 0;
      en_m[g] = 0;
      ev_m[g] = 0;
      cond_m[g] = 0;
      rd(SES_CMD_RD_COND, g, 0, "cond after reset");
      rd(SES_CMD_RD_EVENT, g, 0, "event after reset");
      rd(SES_CMD_RD_ENABLE, g, 0, "enable after reset");
      rd(SES_CMD_RD_RISE, g, 16'hFFFF, "rise after reset");
      rd(SES_CMD_RD_FALL, g, 0, "fall after reset");
    end
    // new edge coinciding with an event read must survive it
    cmd(SES_CMD_WR_ENABLE, 1, 512);
    en_m[1] = 512;
    lvl[6] = 1'h1;
    @(negedge core_clk_i);
    chk("summary before latch", 0, {15'h0000, oper_summary_o});
    cmd(SES_CMD_RD_EVENT, 1, 0);
    chk("event read at edge", 0, rd_data);
    cond_m[1] = 512;
    ev_m[1] = 512;
    sums();
    rd(SES_CMD_RD_EVENT, 1, 512, "kept event");
    ev_m[1] = 0;
    sums();
    lvl[7] = 1'h1;
    settle();
    rd(SES_CMD_RD_COND, 1, 0, "partition cond");
    // enable clearing by zero write, preset; ignored while frozen
    cmd(SES_CMD_WR_ENABLE, 0, 16'h0105);
    rd(SES_CMD_RD_ENABLE, 0, 16'h0105, "enable weights");
    cmd(SES_CMD_WR_ENABLE, 0, 0);
    chk("write answer", 0, {15'h0000, rv});
    chk("held answer data", 16'h0105, rd_data);
    rd(SES_CMD_RD_ENABLE, 0, 0, "enable zero write");
    cmd(SES_CMD_WR_ENABLE, 0, 16'h0105);
    cmd(SES_CMD_PRESET, 0, 0);
    en_m[1] = 0;
    rd(SES_CMD_RD_ENABLE, 0, 0, "ques enable preset");
    rd(SES_CMD_RD_ENABLE, 1, 0, "oper enable preset");
    ce_i = 1'h0;
    cmd(SES_CMD_WR_ENABLE, 0, 1);
    ce_i = 1'h1;
    rd(SES_CMD_RD_ENABLE, 0, 0, "frozen write");
    // instrument reset keeps a standing storage error only
    lvl = 8'h08;
    pulse(3);
    pulse(0);
    settle();
    pulse(5);
    settle();
    rd(SES_CMD_RD_COND, 0, 256, "ques cond inst reset");
    rd(SES_CMD_RD_COND, 1, 0, "oper cond inst reset");
    // random masks, monitor levels and sequencer strobes
    for (int i = 0; i < 40; i++) begin
      r = $random(seed);
      rise_m[r[0]] = r[31:16];
      cmd(SES_CMD_WR_RISE, r[0], r[31:16]);
      r = $random(seed);
      fall_m[r[0]] = r[31:16];
      cmd(SES_CMD_WR_FALL, r[0], r[31:16]);
      r = $random(seed);
      en_m[r[0]] = r[31:16];
      cmd(SES_CMD_WR_ENABLE, r[0], r[31:16]);
      r = $random(seed);
      // monitors settle first: a same-edge meas change would glitch overrange
      lvl[3:0] = r[3:0];
      settle();
      lvl[7:4] = r[7:4];
      pulse(r[10:8] % 7);
      settle();
      for (int g = 0; g < 2; g++) begin
        rd(SES_CMD_RD_COND, g, cond_m[g], "cond");
        rd(SES_CMD_RD_COND, g, cond_m[g], "cond reread");
        rd(SES_CMD_RD_RISE, g, rise_m[g], "rise");
        rd(SES_CMD_RD_FALL, g, fall_m[g], "fall");
        rd(SES_CMD_RD_ENABLE, g, en_m[g], "enable");
        sums();
        if (r[11] == g) begin
          rd(SES_CMD_RD_EVENT, g, ev_m[g], "event");
          ev_m[g] = 0;
          sums();
        end
      end
    end
    lvl = 8'h00;
    pulse(2);
    settle();
    cmd(SES_CMD_CLEAR_STATUS, 1, 0);
    ev_m[0] = 0;
    ev_m[1] = 0;
    sums();
    rd(SES_CMD_RD_EVENT, 0, 0, "ques event cleared");
    rd(SES_CMD_RD_EVENT, 1, 0, "oper event cleared");
    end_sim();
  end
endmodule
